/* File: gcac_access_control.v */
// guest coprocessor access decision and field-change exception unit
`timescale 1ns/1ps
`default_nettype none
`include "gcac_defines.vh"

module gcac_access_control
#(
  parameter RSV_IMPL_MASK = 8'h00  // per reserved slot: 1 = implementation reserved
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        acc_valid,            // guest access request, one cycle
  input  wire        acc_write,            // 1 = write, 0 = read
  input  wire [4:0]  acc_reg,              // register number
  input  wire [2:0]  acc_sel,              // select
  input  wire [31:0] acc_wdata,            // value the guest writes
  input  wire [31:0] acc_cur,              // current value of that register
  input  wire        reg_replicated,       // register exists in guest context
  input  wire        presence_writable,    // presence bit root writable
  input  wire        presence_bit,         // current presence bit value
  input  wire        root_reg_present,     // matching root register exists
  input  wire        coprocessor_access_enable,
  input  wire        config_access_enable,
  input  wire        mode_change_detect,
  input  wire        cop1_change_permit,
  input  wire        cop2_change_permit,
  input  wire        other_register_guard,
  input  wire        field_change_disable,
  input  wire        hw_exc_level_change,  // hardware changed guest exception level
  input  wire        hw_multi_match_change, // hardware changed multi-match bit
  input  wire        root_reduced_power,   // root copy of power bit
  output reg  [1:0]  decision_ff,          // registered decision code
  output reg         privileged_sensitive_trap_ff,
  output reg         software_field_change_exc_ff,
  output reg         hardware_field_change_exc_ff,
  output reg         access_undefined_ff,
  output reg         system_reduced_power_ff
);

  // ==========================================================
  // register class decode
  // ==========================================================
  // reserved slot index, 0..7; bit 3 flags a reserved register
  function [3:0] rsv_slot;
    input [4:0] r;
    input [2:0] s;
    begin
      rsv_slot = 4'h0;
      if (r == `GCAC_REG_RSV22)
        rsv_slot = 4'h8 | 4'h6;                       // all selects of 22
      else if ((s == `GCAC_SEL_RSV6) || (s == `GCAC_SEL_RSV7))
      begin
        if (r == `GCAC_REG_RSV9)
          rsv_slot = {2'h2, 1'b0, s[0]};
        else if (r == `GCAC_REG_RSV11)
          rsv_slot = {2'h2, 1'b1, s[0]};
        else if (r == `GCAC_REG_CONFIG)
          rsv_slot = {2'h3, 1'b0, s[0]};
      end
    end
  endfunction

  // exact register and select match
  function hit;
    input [4:0] r;
    input [2:0] s;
    input [4:0] rr;
    input [2:0] ss;
    begin
      hit = (r == rr) && (s == ss);
    end
  endfunction

  wire [3:0] slot      = rsv_slot(acc_reg, acc_sel);
  wire       is_rsv    = slot[3];
  wire       is_impl   = is_rsv && RSV_IMPL_MASK[slot[2:0]];
  wire       is_ident  = hit(acc_reg, acc_sel, `GCAC_REG_IDENT, `GCAC_SEL_IDENT) |
                         hit(acc_reg, acc_sel, `GCAC_REG_IDENT, `GCAC_SEL_DMAP) |
                         hit(acc_reg, acc_sel, `GCAC_REG_IDENT, `GCAC_SEL_CMGCR);
  wire       is_config = (acc_reg == `GCAC_REG_CONFIG) && !is_rsv;
  wire       is_status = hit(acc_reg, acc_sel, `GCAC_REG_STATUS, `GCAC_SEL_STATUS);
  wire       is_intctl = hit(acc_reg, acc_sel, `GCAC_REG_INTCTL, `GCAC_SEL_INTCTL);
  wire       is_cause  = hit(acc_reg, acc_sel, `GCAC_REG_CAUSE, `GCAC_SEL_CAUSE);
  wire       is_perf   = (acc_reg == `GCAC_REG_PERF);

  // ==========================================================
  // software field change detector
  // ==========================================================
  wire sw_change;  // guest write changes a watched field

  gcac_field_change u_fc
  (
    .is_status          (is_status),
    .is_cause           (is_cause),
    .is_intctl          (is_intctl),
    .is_perf            (is_perf),
    .cur_val            (acc_cur),
    .new_val            (acc_wdata),
    .cop1_change_permit (cop1_change_permit),
    .cop2_change_permit (cop2_change_permit),
    .mode_change_detect (mode_change_detect),
    .sw_change          (sw_change)
  );

  // ==========================================================
  // access decision
  // ==========================================================
  // priority: disabled access, reserved, identity, config, presence table
  reg [1:0] nxt_decision;
  always @*
  begin
    nxt_decision = `GCAC_DEC_PROCEED;
    if (!coprocessor_access_enable)
      nxt_decision = `GCAC_DEC_TRAP;
    else if (is_rsv)
    begin
      // implementation slots skip the guard, needs are unknown
      if (!is_impl && other_register_guard)
        nxt_decision = `GCAC_DEC_TRAP;
      else
        nxt_decision = `GCAC_DEC_UNDEF;               // reads and writes stay undefined
    end
    else if (is_ident)
      nxt_decision = `GCAC_DEC_TRAP;                  // hypervisor emulates
    else if (is_config && acc_write && !config_access_enable)
      nxt_decision = `GCAC_DEC_TRAP;
    else if (!reg_replicated)
    begin
      if (presence_writable && presence_bit)
        nxt_decision = `GCAC_DEC_TRAP;                // root emulates
      else
        nxt_decision = `GCAC_DEC_UNDEF;
    end
    else if (presence_writable && !presence_bit)
      nxt_decision = `GCAC_DEC_UNDEF;
    else
      nxt_decision = `GCAC_DEC_PROCEED;
    // a non-identity trap with no root register behind it is unpredictable
    if ((nxt_decision == `GCAC_DEC_TRAP) && !root_reg_present && !is_ident)
      nxt_decision = `GCAC_DEC_UNDEF;
  end

  // ==========================================================
  // field change qualification
  // ==========================================================
  // software change exceptions only on an access that proceeds; disable masks all
  wire nxt_sfc = acc_valid && acc_write && !field_change_disable &&
                 (nxt_decision == `GCAC_DEC_PROCEED) && sw_change;
  // hardware changes: exception level only with detect, multi-match without detect
  wire nxt_hfc = !field_change_disable &&
                 ((hw_exc_level_change && mode_change_detect) |
                  hw_multi_match_change);

  // ==========================================================
  // output registers
  // ==========================================================
  // pulses last one cycle after the access; decision holds until next access
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      decision_ff                  <= `GCAC_DEC_PROCEED;
      privileged_sensitive_trap_ff <= 1'b0;
      software_field_change_exc_ff <= 1'b0;
      hardware_field_change_exc_ff <= 1'b0;
      access_undefined_ff          <= 1'b0;
      system_reduced_power_ff      <= 1'b0;
    end
    else
    begin
      if (acc_valid)
        decision_ff <= nxt_decision;
      privileged_sensitive_trap_ff <= acc_valid && (nxt_decision == `GCAC_DEC_TRAP);
      access_undefined_ff          <= acc_valid && (nxt_decision == `GCAC_DEC_UNDEF);
      software_field_change_exc_ff <= nxt_sfc;
      hardware_field_change_exc_ff <= nxt_hfc;
      // guest power bit never reaches the system, root copy alone
      system_reduced_power_ff      <= root_reduced_power;
    end
  end

endmodule
`default_nettype wire

/* File: gcac_access_control_properties.sv */
// concurrent properties of the guest coprocessor access control block
`timescale 1ns/1ps
`default_nettype none
`include "gcac_defines.vh"

module gcac_access_control_properties
#(
  parameter RSV_IMPL_MASK = 8'h00  // same slot marking as the design
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [4:0]  acc_reg,
  input wire logic [2:0]  acc_sel,
  input wire logic [31:0] acc_wdata,
  input wire logic [31:0] acc_cur,
  input wire logic        reg_replicated,
  input wire logic        presence_writable,
  input wire logic        presence_bit,
  input wire logic        root_reg_present,
  input wire logic        coprocessor_access_enable,
  input wire logic        config_access_enable,
  input wire logic        mode_change_detect,
  input wire logic        other_register_guard,
  input wire logic        field_change_disable,
  input wire logic        hw_exc_level_change,
  input wire logic        hw_multi_match_change,
  input wire logic        root_reduced_power,
  input wire logic [1:0]  decision_ff,
  input wire logic        privileged_sensitive_trap_ff,
  input wire logic        software_field_change_exc_ff,
  input wire logic        hardware_field_change_exc_ff,
  input wire logic        access_undefined_ff,
  input wire logic        system_reduced_power_ff
);
  // ========
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ========
  // building blocks: a qualified access, then the one-cycle answer
  sequence s_acc(r, s, c);
    acc_valid && acc_reg == r && acc_sel == s && c;
  endsequence
  sequence s_trap;
    privileged_sensitive_trap_ff && decision_ff == `GCAC_DEC_TRAP;
  endsequence
  sequence s_undef;
    access_undefined_ff && decision_ff == `GCAC_DEC_UNDEF;
  endsequence

  // ========
  // access decisions
  a_ident_trap: assert property (s_acc(`GCAC_REG_IDENT, `GCAC_SEL_IDENT, 1'b1) |=> s_trap)
    else $error("identity register access did not trap");
  a_cfg_write: assert property (s_acc(`GCAC_REG_CONFIG, 3'h0, acc_write &&
      !config_access_enable && root_reg_present) |=> s_trap)
    else $error("config write with access off did not trap");
  a_rsv_guard: assert property (s_acc(`GCAC_REG_RSV9, `GCAC_SEL_RSV6,
      other_register_guard && root_reg_present && !RSV_IMPL_MASK[0]) |=> s_trap)
    else $error("guarded reserved slot did not trap");
  a_access_off: assert property (acc_valid && !coprocessor_access_enable && root_reg_present
      |=> s_trap)
    else $error("access with coprocessor disabled did not trap");
  a_root_only: assert property (acc_valid && acc_reg == `GCAC_REG_WATCHLO &&
      !reg_replicated && presence_writable && presence_bit && root_reg_present |=> s_trap)
    else $error("root only register did not trap");
  a_rep_off: assert property (acc_valid && acc_reg == `GCAC_REG_WATCHLO &&
      reg_replicated && presence_writable && !presence_bit && coprocessor_access_enable
      |=> s_undef)
    else $error("disabled replicated register not undefined");

  // ========
  // field change exceptions and system power mode; an unchanged write must stay quiet
  a_same_quiet: assert property (acc_valid && acc_write && acc_wdata == acc_cur
      |=> !software_field_change_exc_ff)
    else $error("unchanged write raised a field change");
  a_fcd_quiet: assert property (field_change_disable
      |=> !software_field_change_exc_ff && !hardware_field_change_exc_ff)
    else $error("field change raised while disabled");
  a_hw_level: assert property (hw_exc_level_change && !hw_multi_match_change &&
      !field_change_disable
      |=> hardware_field_change_exc_ff == $past(mode_change_detect))
    else $error("exception level change did not follow mode detect");
  a_power: assert property (!$past(rst)
      |-> system_reduced_power_ff == $past(root_reduced_power))
    else $error("system power mode not driven by root copy");
endmodule

bind gcac_access_control gcac_access_control_properties #(.RSV_IMPL_MASK(RSV_IMPL_MASK))
  gcac_access_control_properties_i (.*);
`default_nettype wire

/* File: gcac_defines.vh */
// constants for the guest coprocessor access control block
`ifndef GCAC_DEFINES_VH
`define GCAC_DEFINES_VH
// register numbers
`define GCAC_REG_STATUS   5'h0c
`define GCAC_REG_INTCTL   5'h0c
`define GCAC_REG_CAUSE    5'h0d
`define GCAC_REG_IDENT    5'h0f
`define GCAC_REG_CONFIG   5'h10
`define GCAC_REG_WATCHLO  5'h12
`define GCAC_REG_WATCHHI  5'h13
`define GCAC_REG_PERF     5'h19
`define GCAC_REG_RSV9     5'h09
`define GCAC_REG_RSV11    5'h0b
`define GCAC_REG_RSV22    5'h16
// selects
`define GCAC_SEL_STATUS   3'h0
`define GCAC_SEL_INTCTL   3'h1
`define GCAC_SEL_CAUSE    3'h0
`define GCAC_SEL_IDENT    3'h0
`define GCAC_SEL_DMAP     3'h2
`define GCAC_SEL_CMGCR    3'h3
`define GCAC_SEL_RSV6     3'h6
`define GCAC_SEL_RSV7     3'h7
// status field positions
`define GCAC_ST_COP1_USE  29
`define GCAC_ST_COP2_USE  30
`define GCAC_ST_RED_PWR   27
`define GCAC_ST_FPU_MODE  26
`define GCAC_ST_EXT_EN    24
`define GCAC_ST_BOOT_VEC  22
`define GCAC_ST_MULTI_HIT 21
`define GCAC_ST_SOFT_RST  20
`define GCAC_ST_NMI       19
`define GCAC_ST_IMPL_HI   17
`define GCAC_ST_IMPL_LO   16
`define GCAC_ST_OPMODE_HI 4
`define GCAC_ST_OPMODE_LO 3
`define GCAC_ST_ERR_LVL   2
`define GCAC_ST_EXC_LVL   1
// cause and intctl field positions
`define GCAC_CA_CNT_DIS   27
`define GCAC_CA_VEC_SEL   23
`define GCAC_IC_SPACE_HI  9
`define GCAC_IC_SPACE_LO  5
// perf control event fields
`define GCAC_PC_EV_HI     10
`define GCAC_PC_EV_LO     5
`define GCAC_PC_EVX_HI    14
`define GCAC_PC_EVX_LO    11
// access decision codes
`define GCAC_DEC_PROCEED  2'h0
`define GCAC_DEC_TRAP     2'h1
`define GCAC_DEC_UNDEF    2'h2
`endif

/* File: gcac_field_change.v */
// field-change detector for guest status, cause, intctl and perf control writes
`timescale 1ns/1ps
`default_nettype none
`include "gcac_defines.vh"

module gcac_field_change
(
  input  wire        is_status,
  input  wire        is_cause,
  input  wire        is_intctl,
  input  wire        is_perf,
  input  wire [31:0] cur_val,
  input  wire [31:0] new_val,
  input  wire        cop1_change_permit,
  input  wire        cop2_change_permit,
  input  wire        mode_change_detect,
  output reg         sw_change
);

  // ==========================================================
  // helpers
  // ==========================================================
  // one bit differs between old and new value
  function bit_diff;
    input [31:0] a;
    input [31:0] b;
    input integer pos;
    begin
      bit_diff = a[pos] ^ b[pos];
    end
  endfunction

  wire [31:0] diff = cur_val ^ new_val;  // changed bits only

  // ==========================================================
  // detection
  // ==========================================================
  // only a real change counts; an unchanged write completes normally
  always @*
  begin
    sw_change = 1'b0;
    if (is_status)
    begin
      if (bit_diff(cur_val, new_val, `GCAC_ST_COP1_USE) && !cop1_change_permit)
        sw_change = 1'b1;
      if (bit_diff(cur_val, new_val, `GCAC_ST_COP2_USE) && !cop2_change_permit)
        sw_change = 1'b1;
      if (diff[`GCAC_ST_RED_PWR])
        sw_change = 1'b1;
      if (diff[`GCAC_ST_FPU_MODE] | diff[`GCAC_ST_EXT_EN] | diff[`GCAC_ST_BOOT_VEC] |
          diff[`GCAC_ST_MULTI_HIT] | diff[`GCAC_ST_SOFT_RST] | diff[`GCAC_ST_NMI] |
          diff[`GCAC_ST_ERR_LVL] | (|diff[`GCAC_ST_IMPL_HI:`GCAC_ST_IMPL_LO]))
        sw_change = 1'b1;
      if ((|diff[`GCAC_ST_OPMODE_HI:`GCAC_ST_OPMODE_LO]) && mode_change_detect)
        sw_change = 1'b1;
    end
    if (is_cause && (diff[`GCAC_CA_CNT_DIS] | diff[`GCAC_CA_VEC_SEL]))
      sw_change = 1'b1;
    if (is_intctl && (|diff[`GCAC_IC_SPACE_HI:`GCAC_IC_SPACE_LO]))
      sw_change = 1'b1;
    if (is_perf && ((|diff[`GCAC_PC_EV_HI:`GCAC_PC_EV_LO]) |
                    (|diff[`GCAC_PC_EVX_HI:`GCAC_PC_EVX_LO])))
      sw_change = 1'b1;
  end

endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the guest coprocessor access control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module tb_top;
  // ========
  // controls packed as {rep,pwr,pbit,root,cpe,cfe,mdc,p1,p2,grd,fdis}; base = free access
  localparam B = 11'h5e0, REP = 11'h400, PW = 11'h200, PB = 11'h100, RT = 11'h080;
  localparam CP = 11'h040, CFE = 11'h020, MDC = 11'h010, P1 = 11'h008, P2 = 11'h004;
  localparam GRD = 11'h002, FD = 11'h001;
  localparam PRO = 6'h00, TRP = 6'h18, UND = 6'h24, SFC = 6'h02;  // {dec,trap,undef,sfc,hfc}
  logic        clk, rst, acc_valid, acc_write, root_reduced_power;
  logic        hw_exc_level_change, hw_multi_match_change;
  logic [4:0]  acc_reg;
  logic [2:0]  acc_sel;
  logic [31:0] acc_wdata, acc_cur;
  logic [10:0] ctl;
  wire         reg_replicated, presence_writable, presence_bit, root_reg_present;
  wire         coprocessor_access_enable, config_access_enable, mode_change_detect;
  wire         cop1_change_permit, cop2_change_permit, other_register_guard, field_change_disable;
  wire  [1:0]  decision_ff;
  wire         privileged_sensitive_trap_ff, software_field_change_exc_ff;
  wire         hardware_field_change_exc_ff, access_undefined_ff, system_reduced_power_ff;
  wire  [5:0]  obs = {decision_ff, privileged_sensitive_trap_ff, access_undefined_ff,
                      software_field_change_exc_ff, hardware_field_change_exc_ff};
  int          error_cnt, checks, i;
  // reserved slots; reg 22 is marked implementation reserved below
  logic [4:0]  rr [8] = '{5'h09, 5'h09, 5'h0b, 5'h0b, 5'h10, 5'h10, 5'h16, 5'h16};
  logic [2:0]  ss [8] = '{3'h6, 3'h7, 3'h6, 3'h7, 3'h6, 3'h7, 3'h0, 3'h5};
  // watched fields as {reg,sel,bit}: status bits, cause count/vector, spacing, perf event
  logic [15:0] ft [15] = '{16'h601b, 16'h601a, 16'h6018, 16'h6016, 16'h6015, 16'h6014,
    16'h6013, 16'h6011, 16'h6010, 16'h6002, 16'h681b, 16'h6817, 16'h6105, 16'hc905, 16'hc90b};

  assign {reg_replicated, presence_writable, presence_bit, root_reg_present,
          coprocessor_access_enable, config_access_enable, mode_change_detect,
          cop1_change_permit, cop2_change_permit, other_register_guard,
          field_change_disable} = ctl;

  gcac_access_control #(.RSV_IMPL_MASK(8'h40)) gcac_access_control_i (.*);

  // ========
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // one access, driven at an edge; the answer lands one edge later
  // controls settle with the access, never while an earlier one is in flight
  task automatic acc(input [10:0] c, input w, input [4:0] r, input [2:0] s,
                     input [31:0] wd, input [31:0] cur);
    @(posedge clk);
    ctl <= c;
    {acc_write, acc_reg, acc_sel, acc_wdata, acc_cur} <= {w, r, s, wd, cur};
    acc_valid <= 1'b1;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input [10:0] c, input [4:0] r, input [2:0] s);
    acc(c, 1'b0, r, s, 32'h0, 32'h0);
  endtask

  // hardware change pulses, no access alongside
  task automatic hw(input [10:0] c, input e, input t);
    @(posedge clk);
    ctl <= c;
    {hw_exc_level_change, hw_multi_match_change} <= {e, t};
    @(posedge clk);
    {hw_exc_level_change, hw_multi_match_change} <= 2'h0;
    #1;
  endtask

  // ========
  // scenarios
  task automatic t_presence;
    rd(B ^ REP ^ PB, 5'h12, 3'h0);
    `CHK("absent", UND, obs)
    rd(B, 5'h12, 3'h0);
    `CHK("fixed", PRO, obs)
    rd(B ^ REP ^ PW, 5'h12, 3'h0);
    `CHK("root only", TRP, obs)
    rd(B ^ REP ^ PW ^ RT, 5'h12, 3'h0);
    `CHK("no root", UND, obs)
    rd(B ^ REP ^ PW ^ PB, 5'h12, 3'h0);
    `CHK("root off", UND, obs)
    rd(B ^ PW ^ PB, 5'h12, 3'h0);
    `CHK("rep off", UND, obs)
    rd(B ^ PW, 5'h12, 3'h0);
    `CHK("rep on", PRO, obs)
    $display("test presence done");
  endtask

  task automatic t_reserved;
    for (i = 0; i < 8; i++)
    begin
      rd(B ^ GRD, rr[i], ss[i]);
      `CHK("rsv guard", (i < 6) ? TRP : UND, obs)
      rd(B ^ CP, rr[i], ss[i]);
      `CHK("rsv access off", TRP, obs)
      rd(B, rr[i], ss[i]);
      `CHK("rsv open", UND, obs)
    end
    $display("test reserved done");
  endtask

  task automatic t_special;
    rd(B ^ RT, 5'h0f, 3'h0);
    `CHK("ident", TRP, obs)
    rd(B, 5'h0f, 3'h2);
    `CHK("map base", TRP, obs)
    rd(B, 5'h0f, 3'h3);
    `CHK("cm base", TRP, obs)
    acc(B ^ CFE, 1'b1, 5'h10, 3'h0, 32'h1, 32'h0);
    `CHK("cfg write", TRP, obs)
    rd(B ^ CFE, 5'h10, 3'h0);
    `CHK("cfg read", PRO, obs)
    $display("test special done");
  endtask

  task automatic t_fields;
    for (i = 0; i < 15; i++)
    begin
      acc(B, 1'b1, ft[i][15:11], ft[i][10:8], 32'h1 << ft[i][7:0], 32'h0);
      `CHK("field", SFC, obs)
    end
    for (i = 0; i < 4; i++)
    begin
      acc(i[0] ? B ^ P1 : B ^ P2, 1'b1, 5'h0c, 3'h0, i[1] ? 32'h40000000 : 32'h20000000, 32'h0);
      `CHK("usable", (i[0] ^ i[1]) ? PRO : SFC, obs)
    end
    acc(B, 1'b1, 5'h0c, 3'h0, 32'h8, 32'h0);
    `CHK("mode off", PRO, obs)
    acc(B ^ MDC, 1'b1, 5'h0c, 3'h0, 32'h0, 32'h18);
    `CHK("mode on", SFC, obs)
    acc(B, 1'b1, 5'h0d, 3'h0, 32'h08000100, 32'h08000000);
    `CHK("cause other", PRO, obs)
    acc(B ^ FD, 1'b1, 5'h0c, 3'h0, 32'h4, 32'h0);
    `CHK("disabled", PRO, obs)
    $display("test fields done");
  endtask

  task automatic t_hw;
    hw(B ^ MDC, 1'b1, 1'b0);
    `CHK("level detect", 1'b1, hardware_field_change_exc_ff)
    hw(B, 1'b1, 1'b0);
    `CHK("level plain", 1'b0, hardware_field_change_exc_ff)
    hw(B ^ MDC ^ FD, 1'b1, 1'b1);
    `CHK("hw off", 1'b0, hardware_field_change_exc_ff)
    hw(B, 1'b0, 1'b1);
    `CHK("multi match", 1'b1, hardware_field_change_exc_ff)
    @(posedge clk);
    root_reduced_power <= 1'b1;
    acc(B, 1'b1, 5'h0c, 3'h0, 32'h0, 32'h08000000);
    `CHK("root power", 1'b1, system_reduced_power_ff)
    $display("test hardware done");
  endtask

  // ========
  // verdict, shared by the main sequence and the watchdog
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // some 64 accesses of two cycles each; 4000 cycles is ample margin
  initial
  begin
    #20000;
    error_cnt++;
    wrap_up;
  end

  initial
  begin
    rst = 1'b1;
    ctl = B;
    {acc_valid, acc_write, acc_reg, acc_sel, acc_wdata, acc_cur} = '0;
    {hw_exc_level_change, hw_multi_match_change, root_reduced_power} = 3'h0;
    error_cnt = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_presence;
    t_reserved;
    t_special;
    t_fields;
    t_hw;
    wrap_up;
  end
endmodule
`default_nettype wire
